// ===== cdsp_consts.svh
// Constants for the clock divider, sync and power-state block
`ifndef CDSP_CONSTS_SVH
`define CDSP_CONSTS_SVH
`define CDSP_SYNC_REG_ADDR 9'h109
`define CDSP_SYNC_REG_RESET 8'h00
`define CDSP_SYNC_EN_BIT 0
`define CDSP_SYNC_ONCE_BIT 1
`define CDSP_DIV_RATIO_MAX 8
`define CDSP_DIV_RATIO_RESET 3'h0
`define CDSP_CLK_PERIOD_NS 50
`define CDSP_RELOCK_TIME_NS 1500
`define CDSP_RELOCK_CYCLES ((`CDSP_RELOCK_TIME_NS + `CDSP_CLK_PERIOD_NS - 1) / `CDSP_CLK_PERIOD_NS)
`define CDSP_WAKE_MIN_CYCLES 4
`define CDSP_WAKE_MAX_CYCLES 1023
`define CDSP_STBY_WAKE_CYCLES 2
`define CDSP_DCS_MIN_FREQ_MHZ 20
`endif

// ===== cdsp_pkg.sv
// Types for the clock divider, sync and power-state block
package cdsp_pkg;
    typedef enum logic [1:0] {
        CDSP_RUN = 2'b00,
        CDSP_DOWN = 2'b01,
        CDSP_WAKE = 2'b11,
        CDSP_STBY = 2'b10
    } cdsp_pwr_t;

    typedef struct packed {
        logic write;
        logic [8:0] addr;
        logic [7:0] wdata;
    } cdsp_reg_req_t;

    typedef struct packed {
        logic clk_run;
        logic ref_on;
        logic bias_on;
        logic drv_oe;
    } cdsp_pwr_ctl_t;
endpackage

// ===== cdsp_divider.sv
// Integer clock divider with sync reset and even duty output
`timescale 1ns/10ps
`default_nettype none
`include "cdsp_consts.svh"
module cdsp_divider
#(
    parameter int RATIO_W = 3
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic realign,
    input wire logic [RATIO_W-1:0] ratio_m1,
    input wire logic dcs_en,
    // Enables out
    output logic rise_en,
    output logic div_level
);
    import cdsp_pkg::*;

    logic [RATIO_W-1:0] cnt_q, cnt_d;
    logic lvl_q, lvl_d;
    logic [RATIO_W:0] half;

    // Half point sets the falling edge position
    always_comb
    begin
        half = ({1'b0, ratio_m1} + {{RATIO_W{1'b0}}, 1'b1}) >> 1;
        cnt_d = cnt_q;
        lvl_d = lvl_q;
        if (!run)
        begin
            cnt_d = '0;
            lvl_d = 1'b0;
        end
        else if (realign)
        begin
            cnt_d = '0; // R3
            lvl_d = 1'b1;
        end
        else
        begin
            cnt_d = (cnt_q >= ratio_m1) ? '0 : cnt_q + 1'b1; // R1
            if (cnt_d == '0)
                lvl_d = 1'b1;
            else if (dcs_en)
                lvl_d = ({1'b0, cnt_d} < half); // R4
            else
                lvl_d = (cnt_d == '0);
        end
    end

    // Counter and level registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            lvl_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            lvl_q <= lvl_d;
        end
    end

    // Rising edge of divided clock is the sample instant
    assign rise_en = run && (realign || cnt_d == '0); // R12
    // Next level, so the top registers it in step with rise_en
    assign div_level = lvl_d;
endmodule
`default_nettype wire

// ===== cdsp_top.sv
// Clock divider, alignment sync and power-state control top
//
// What this block does
// R1: Divide the input clock by an integer ratio from 1 to 8.
// R2: Divider_sync_control low bits select realign on every pulse or first only.
// R3: An accepted alignment pulse returns the divider to its initial state.
// R4: Stabiliser regenerates the falling edge for an even high/low ratio.
// R5: Stabiliser need not work below about 20 MHz input clock.
// R6: Controller waits 1.5 us after a clock rate change before trusting data.
// R7: Power-down is entered by register command or by the pin driven high.
// R8: All output drivers are high impedance while powered down.
// R9: Pin driven low leaves power-down and resumes normal operation.
// R10: Power-down stops clock, reference and bias; wake-up grows with time down.
// R11: Register-only standby keeps the reference on for a faster wake-up.
// R12: Each sample is taken on the rising edge of the divided clock.
// R13: Alignment input edge-detected; a write arms first-pulse mode, a pulse disarms.
`timescale 1ns/10ps
`default_nettype none
`include "cdsp_consts.svh"
module cdsp_top
#(
    parameter int RATIO_MAX = `CDSP_DIV_RATIO_MAX,
    parameter int RELOCK_CYCLES = `CDSP_RELOCK_CYCLES,
    parameter int WAKE_MAX = `CDSP_WAKE_MAX_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire cdsp_pkg::cdsp_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Divider ratio and power commands from the control port
    input wire logic [2:0] div_ratio_m1,
    input wire logic dcs_enable,
    input wire logic cmd_powerdown,
    input wire logic cmd_standby,
    input wire logic rate_changed,
    // Pins
    input wire logic sync_in,
    input wire logic powerdown_pin,
    // Outputs
    output logic sample_en,
    output logic div_clk,
    output cdsp_pkg::cdsp_pwr_ctl_t pwr_ctl,
    output logic dcs_locked
);
    import cdsp_pkg::*;

    localparam int RW = $clog2(RATIO_MAX);
    localparam int WW = $clog2(WAKE_MAX + 1);
    localparam int LW = $clog2(RELOCK_CYCLES + 1);

    // Elaboration checks on parameters
    initial
    begin
        if (RATIO_MAX < 2 || RATIO_MAX > 8 || RW != 3)
            $error("cdsp_top: RATIO_MAX must be 5 to 8");
        if (RELOCK_CYCLES < 1 || WAKE_MAX < `CDSP_WAKE_MIN_CYCLES)
            $error("cdsp_top: counts too small");
    end

    // Register write decode, used once for the sync register
    function automatic logic hit(input cdsp_reg_req_t r);
        hit = r.write && (r.addr == `CDSP_SYNC_REG_ADDR);
    endfunction

    logic [7:0] sreg_q, sreg_d;
    logic armed_q, armed_d;
    logic [1:0] sync_q, sync_d;
    logic realign;
    logic sync_rise;

    // Sync input is taken synchronous; newer stage high with older stage low gives the edge
    assign sync_rise = sync_q[0] && !sync_q[1]; // R13

    // Accepted pulse depends on mode bits
    always_comb
    begin
        realign = 1'b0;
        if (sync_rise && sreg_q[`CDSP_SYNC_EN_BIT])
        begin
            if (sreg_q[`CDSP_SYNC_ONCE_BIT])
                realign = armed_q; // R2
            else
                realign = 1'b1; // R2
        end
    end

    // Sync register, arm flag and input stages
    always_comb
    begin
        sreg_d = sreg_q;
        armed_d = armed_q;
        sync_d = {sync_q[0], sync_in};
        if (realign)
            armed_d = 1'b0; // R13
        // A write in the pulse cycle re-arms: the write wins as the later event
        if (hit(reg_req))
        begin
            sreg_d = reg_req.wdata;
            armed_d = 1'b1; // R13
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sreg_q <= `CDSP_SYNC_REG_RESET;
            armed_q <= 1'b0;
            sync_q <= 2'b00;
        end
        else
        begin
            sreg_q <= sreg_d;
            armed_q <= armed_d;
            sync_q <= sync_d;
        end
    end

    // Power state machine
    cdsp_pwr_t st_q, st_d;
    logic [WW-1:0] down_q, down_d;
    logic [WW-1:0] wake_q, wake_d;
    logic want_down;

    assign want_down = cmd_powerdown || powerdown_pin; // R7

    always_comb
    begin
        st_d = st_q;
        down_d = down_q;
        wake_d = wake_q;
        unique case (st_q)
            CDSP_RUN:
            begin
                down_d = '0;
                if (want_down)
                    st_d = CDSP_DOWN;
                else if (cmd_standby)
                    st_d = CDSP_STBY; // R11
            end
            CDSP_DOWN:
            begin
                // Longer time down gives a longer recharge, saturating
                if (down_q < WW'(WAKE_MAX))
                    down_d = down_q + 1'b1; // R10
                if (!want_down)
                begin
                    st_d = CDSP_WAKE; // R9
                    wake_d = (down_q < WW'(`CDSP_WAKE_MIN_CYCLES)) ?
                        WW'(`CDSP_WAKE_MIN_CYCLES) : down_q; // R10
                end
            end
            CDSP_STBY:
            begin
                if (want_down)
                    st_d = CDSP_DOWN;
                else if (!cmd_standby)
                begin
                    st_d = CDSP_WAKE;
                    wake_d = WW'(`CDSP_STBY_WAKE_CYCLES); // R11
                end
            end
            CDSP_WAKE:
            begin
                if (want_down)
                    st_d = CDSP_DOWN;
                else if (wake_q <= WW'(1))
                    st_d = CDSP_RUN;
                else
                    wake_d = wake_q - 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= CDSP_RUN;
            down_q <= '0;
            wake_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            down_q <= down_d;
            wake_q <= wake_d;
        end
    end

    // Power controls, all registered
    cdsp_pwr_ctl_t ctl_d;
    always_comb
    begin
        ctl_d.clk_run = (st_d == CDSP_RUN); // R10
        ctl_d.ref_on = (st_d != CDSP_DOWN); // R11
        ctl_d.bias_on = (st_d == CDSP_RUN) || (st_d == CDSP_WAKE);
        ctl_d.drv_oe = (st_d == CDSP_RUN); // R8
    end

    // Divider runs only while the internal clock is allowed
    logic rise_en;
    logic div_level;
    cdsp_divider #(.RATIO_W(RW)) u_div
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(st_q == CDSP_RUN),
        .realign(realign),
        .ratio_m1(div_ratio_m1),
        .dcs_en(dcs_enable),
        .rise_en(rise_en),
        .div_level(div_level)
    );

    // Stabiliser relock timer; controller must wait out the flag
    logic [LW-1:0] lock_q, lock_d;
    always_comb
    begin
        lock_d = lock_q;
        if (rate_changed || !dcs_enable || st_q != CDSP_RUN)
            lock_d = LW'(RELOCK_CYCLES); // R6
        else if (lock_q != '0)
            lock_d = lock_q - 1'b1;
    end

    // Output registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_q <= '0;
            reg_rdata <= 8'h00;
            sample_en <= 1'b0;
            div_clk <= 1'b0;
            pwr_ctl <= '0;
            dcs_locked <= 1'b0;
        end
        else
        begin
            lock_q <= lock_d;
            reg_rdata <= {4'h0, armed_q, st_q == CDSP_RUN, sreg_q[1:0]};
            sample_en <= rise_en; // R12
            div_clk <= div_level;
            pwr_ctl <= ctl_d;
            // Below 20 MHz input the loop may never lock; not modelled
            dcs_locked <= dcs_enable && (lock_d == '0); // R5
        end
    end
endmodule
`default_nettype wire

// ===== cdsp_monitor.sv
// Checker for the clock divider, sync and power-state block
`timescale 1ns/10ps
`default_nettype none
module cdsp_monitor
#(
    parameter int RELOCK_CYCLES = 30,
    parameter int WAKE_MAX = 1023
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire cdsp_pkg::cdsp_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Commands and pins
    input wire logic cmd_powerdown,
    input wire logic cmd_standby,
    input wire logic rate_changed,
    input wire logic sync_in,
    input wire logic powerdown_pin,
    // Watched outputs
    input wire logic sample_en,
    input wire logic div_clk,
    input wire cdsp_pkg::cdsp_pwr_ctl_t pwr_ctl,
    input wire logic dcs_locked
);
    import cdsp_pkg::*;
    // Margins allow for registered outputs
    localparam int LOCK_LIM = RELOCK_CYCLES + 2;
    localparam int WAKE_LIM = WAKE_MAX + 4;
    logic want;
    assign want = powerdown_pin | cmd_powerdown;
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Alignment edge seen while realign on every pulse is selected
    sequence s_pulse;
        $rose(sync_in) && reg_rdata[1:0] == 2'b01 && !want && !cmd_standby;
    endsequence
    // Drivers stay off through the wake delay, then full power returns
    sequence s_woken;
        !pwr_ctl.drv_oe [*4] ##[1:WAKE_LIM] pwr_ctl == 4'hF;
    endsequence
    a_sample_high: assert property (sample_en |-> div_clk)
        else $error("sample without divided clock high");
    a_sync_realign: assert property (s_pulse |-> ##[1:3] sample_en)
        else $error("alignment pulse did not realign");
    a_once_disarm: assert property ($rose(sync_in) && reg_rdata[3] && reg_rdata[1:0] == 2'b11
        && !reg_req.write |-> ##[2:4] !reg_rdata[3])
        else $error("first pulse did not disarm");
    a_write_bits: assert property (reg_req.write && reg_req.addr == 9'h109
        |-> ##2 reg_rdata[1:0] == $past(reg_req.wdata[1:0], 2))
        else $error("sync control bits not stored");
    a_down_quiet: assert property (want |-> ##[1:2] pwr_ctl == 4'h0)
        else $error("power-down left something on");
    a_wake_delay: assert property ($fell(want) && !pwr_ctl.drv_oe && !cmd_standby
        |-> s_woken)
        else $error("wake from power-down wrong");
    a_standby_ref: assert property ((cmd_standby && !want) [*2]
        |-> pwr_ctl.ref_on && !pwr_ctl.clk_run)
        else $error("standby without reference");
    a_relock_wait: assert property (rate_changed && pwr_ctl.clk_run
        |=> !dcs_locked ##[1:LOCK_LIM] dcs_locked)
        else $error("relock timing wrong");
endmodule
bind cdsp_top cdsp_monitor #(.RELOCK_CYCLES(RELOCK_CYCLES), .WAKE_MAX(WAKE_MAX)) mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .cmd_powerdown(cmd_powerdown), .cmd_standby(cmd_standby), .rate_changed(rate_changed),
    .sync_in(sync_in), .powerdown_pin(powerdown_pin), .sample_en(sample_en),
    .div_clk(div_clk), .pwr_ctl(pwr_ctl), .dcs_locked(dcs_locked));
`default_nettype wire

// ===== cdsp_ctrl_model.sv
// Board controller model driving the alignment and power-down pins
`timescale 1ns/10ps
`default_nettype none
module cdsp_ctrl_model
(
    // Clock
    input wire logic sys_clk,
    // Requests from the bench
    input wire logic sync_req,
    input wire logic pd_req,
    // Pins toward the block
    output var logic sync_in,
    output var logic powerdown_pin
);
    // Pins start low so the block comes up running
    initial
    begin
        sync_in = 1'b0;
        powerdown_pin = 1'b0;
    end
    // Pins change after the edge; one request cycle gives one pulse
    always @(posedge sys_clk)
    begin
        sync_in <= sync_req;
        powerdown_pin <= pd_req;
    end
endmodule
`default_nettype wire

// ===== cdsp_top_bench.sv
// Self-checking bench for the clock divider, sync and power-state block
`timescale 1ns/10ps
`default_nettype none
module cdsp_top_bench;
    import cdsp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    cdsp_reg_req_t reg_req = '0;
    logic [2:0] div_ratio_m1 = 3'h7;
    logic dcs_enable = 1'b0;
    logic cmd_powerdown = 1'b0;
    logic cmd_standby = 1'b0;
    logic rate_changed = 1'b0;
    logic sync_req = 1'b0;
    logic pd_req = 1'b0;
    logic sync_in;
    logic powerdown_pin;
    logic sample_en;
    logic div_clk;
    logic dcs_locked;
    logic [7:0] reg_rdata;
    cdsp_pwr_ctl_t pwr_ctl;
    int err_total = 0;
    int compares = 0;
    int a;
    int b;
    int n;
    // Half period of the 20 MHz clock
    always #25 sys_clk = ~sys_clk;
    // Small counts keep relock and wake waits short
    cdsp_top #(.RELOCK_CYCLES(3), .WAKE_MAX(8)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .div_ratio_m1(div_ratio_m1), .dcs_enable(dcs_enable), .cmd_powerdown(cmd_powerdown),
        .cmd_standby(cmd_standby), .rate_changed(rate_changed), .sync_in(sync_in),
        .powerdown_pin(powerdown_pin), .sample_en(sample_en), .div_clk(div_clk),
        .pwr_ctl(pwr_ctl), .dcs_locked(dcs_locked));
    cdsp_ctrl_model far (.sys_clk(sys_clk), .sync_req(sync_req), .pd_req(pd_req),
        .sync_in(sync_in), .powerdown_pin(powerdown_pin));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Count falling edges until a divided rise, full power or lock
    task automatic wait_for(input int sel, output int c);
        c = 0;
        do
        begin
            @(negedge sys_clk);
            c++;
        end
        while ((sel == 0 ? sample_en : sel == 1 ? pwr_ctl == 4'hF : dcs_locked) !== 1'b1
            && c < 99);
        if (c >= 99)
        begin
            err_total++;
            stop_test();
        end
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] v);
        reg_req <= '{1'b1, 9'h109, v};
        @(posedge sys_clk);
        reg_req.write <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    // Pulse one cycle after a divided rise, then count to the next rise
    task automatic sync_gap(output int c);
        wait_for(0, c);
        sync_req <= 1'b1;
        @(posedge sys_clk);
        sync_req <= 1'b0;
        wait_for(0, c);
    endtask
    // Power-down or standby by command for k cycles, then time the wake
    task automatic down_for(input logic sb, input int k, output int c);
        {cmd_standby, cmd_powerdown} <= sb ? 2'b10 : 2'b01;
        repeat (k) @(negedge sys_clk);
        chk({4'h0, pwr_ctl} & 8'h0D, sb ? 8'h04 : 8'h00);
        @(posedge sys_clk);
        {cmd_standby, cmd_powerdown} <= 2'b00;
        wait_for(1, c);
    endtask
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk({4'h0, pwr_ctl}, 8'h0F);
        chk(reg_rdata & 8'h0B, 8'h00);
        $display("done reset");
        for (int r = 0; r < 8; r++)
        begin
            @(posedge sys_clk);
            div_ratio_m1 <= r[2:0];
            repeat (3) wait_for(0, n);
            chk(n[7:0], r[7:0] + 8'h1);
        end
        $display("done ratio");
        // Ratio is 8 here, so an unaligned rise comes 7 edges on
        wr(8'h00);
        sync_gap(a);
        chk(a[7:0], 8'h07);
        wr(8'h01);
        sync_gap(a);
        sync_gap(b);
        chk(b[7:0], a[7:0]);
        chk({7'h0, a < 7}, 8'h01);
        wr(8'h03);
        @(negedge sys_clk);
        chk(reg_rdata & 8'h0B, 8'h0B);
        sync_gap(b);
        chk(b[7:0], a[7:0]);
        @(negedge sys_clk);
        chk(reg_rdata & 8'h0B, 8'h03);
        sync_gap(b);
        chk(b[7:0], 8'h07);
        $display("done sync");
        // Divide by 4: even duty with the stabiliser, one high cycle without
        for (int d = 0; d < 2; d++)
        begin
            @(posedge sys_clk);
            div_ratio_m1 <= 3'h3;
            dcs_enable <= d[0];
            repeat (3) wait_for(0, n);
            a = 0;
            repeat (8)
            begin
                @(negedge sys_clk);
                a = a + int'(div_clk === 1'b1);
            end
            chk(a[7:0], d ? 8'h04 : 8'h02);
        end
        rate_changed <= 1'b1;
        @(posedge sys_clk);
        rate_changed <= 1'b0;
        wait_for(2, n);
        chk(n[7:0], 8'h04);
        $display("done duty");
        pd_req <= 1'b1;
        repeat (12) @(negedge sys_clk);
        chk({4'h0, pwr_ctl}, 8'h00);
        @(posedge sys_clk);
        pd_req <= 1'b0;
        wait_for(1, a);
        chk({7'h0, a > 4}, 8'h01);
        down_for(1'b0, 12, a);
        down_for(1'b0, 2, b);
        down_for(1'b1, 12, n);
        chk({6'h0, b < a, n < b}, 8'h03);
        $display("done power");
        stop_test();
    end
endmodule
`default_nettype wire
